// ### hw/link_bringup_map.vh
// Register offsets, reset values, field positions and counts for the
// receive-link bring-up and status block.
// Assumes a 12-bit register address and 8-bit register data.
`ifndef LINK_BRINGUP_MAP_VH
`define LINK_BRINGUP_MAP_VH

// ==========================================================================
// Register offsets
`define OFS_SYNC_MACHINE_CONTROL      12'h03A
`define OFS_RECEIVER_EQUALISER_MODE   12'h268
`define OFS_LANE_PLL_ENABLE           12'h280
`define OFS_LANE_PLL_LOCK_STATUS      12'h281
`define OFS_LINK_ENABLE_AND_SELECT    12'h300
`define OFS_LINK_SUBCLASS             12'h301
`define OFS_MULTIFRAME_DELAY_A        12'h304
`define OFS_MULTIFRAME_DELAY_B        12'h305
`define OFS_RECEIVE_BUFFER_DELAY_A    12'h306
`define OFS_RECEIVE_BUFFER_DELAY_B    12'h307
`define OFS_CODE_GROUP_SYNC_STATUS    12'h470
`define OFS_FRAME_SYNC_STATUS         12'h471
`define OFS_CHECKSUM_GOOD_STATUS      12'h472
`define OFS_ALIGNMENT_SEQUENCE_STATUS 12'h473

// ==========================================================================
// Reset values
`define RST_BYTE                      8'h00
`define RST_SUBCLASS                  8'h00

// ==========================================================================
// Field positions
`define BIT_SYNC_ONE_SHOT             0
`define BIT_SYNC_ARM                  6
`define BIT_SYNC_ENABLE               7
`define BIT_PLL_ENABLE                0
`define BIT_PLL_LOCKED                0
`define BIT_LINK0_ENABLE              0
`define BIT_LINK1_ENABLE              1
`define BIT_LINK_SELECT               2
`define SUBCLASS_ONE                  8'h01

// ==========================================================================
// Control characters and counts
`define CHAR_K28_5                    8'hBC
`define CHAR_K28_0                    8'h1C
`define CHAR_K28_4                    8'h9C
`define CHAR_K28_3                    8'h7C
`define CGS_COUNT                     3'h4
`define ILAS_CONFIG_LEN               4'hE
`define LMFC_PERIOD                   8'h20

`endif

// ### hw/data_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
module data_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             core_clk,
    input  wire             reset_n,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr_reg;
    reg [AW:0]      rd_ptr_reg;
    wire            full;
    wire            empty;
    wire            do_wr;
    wire            do_rd;

    // ======================================================================
    // Flags
    assign full      = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) &&
                       (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
    assign empty     = (wr_ptr_reg == rd_ptr_reg);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign do_wr     = in_valid && !full;
    assign do_rd     = out_ready && !empty;

    // ======================================================================
    // Storage and pointers
    always @(posedge core_clk) begin
        if (do_wr) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    always @* begin
        out_data = mem[rd_ptr_reg[AW-1:0]];
    end

    always @(posedge core_clk) begin
        if (!reset_n) begin
            wr_ptr_reg <= {(AW+1){1'b0}};
            rd_ptr_reg <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

endmodule

// ### hw/link_bringup.v
// Receive-link bring-up, alignment sync machine and per-lane status for
// eight decoded lanes split into two four-lane links.
// Assumes lanes arrive as decoded octets with a control flag, synchronous
// to core_clk, and a separate lane PLL reporting its lock.
`include "link_bringup_map.vh"

module link_bringup #(
    parameter LANES      = 8,
    parameter FIFO_DEPTH = 32,
    parameter FIFO_AW    = 5
) (
    input  wire        core_clk,
    input  wire        reset_n,
    input  wire [11:0] reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [7:0]  reg_rdata,
    output wire        pll_enable,
    input  wire        pll_locked,
    input  wire        sysref,
    input  wire [63:0] serial_lane_inputs,
    input  wire [7:0]  lane_is_control,
    input  wire [7:0]  lane_valid,
    output reg         sync_request_output,
    output wire        lmfc_boundary,
    output wire        fifo_in_ready,
    output wire [31:0] sample_data,
    output wire        sample_valid,
    input  wire        sample_ready
);

    localparam ST_CGS  = 3'h0;
    localparam ST_WAIT = 3'h1;
    localparam ST_ILAS = 3'h2;
    localparam ST_CFG  = 3'h3;
    localparam ST_DATA = 3'h4;

    reg  [7:0] sync_ctrl_reg;
    reg  [7:0] eq_mode_reg;
    reg  [7:0] pll_en_reg;
    reg  [7:0] link_ctrl_reg;
    reg  [7:0] subclass_reg;
    reg  [7:0] mf_delay_a_reg;
    reg  [7:0] mf_delay_b_reg;
    reg  [7:0] rx_delay_a_reg;
    reg  [7:0] rx_delay_b_reg;
    reg        sysref_prev_reg;
    reg  [7:0] lmfc_cnt_reg;
    reg  [7:0] lmfc_cnt_next;
    wire       sysref_edge;
    wire       align_now;
    wire [7:0] cgs_vec;
    wire [7:0] fs_vec;
    wire [7:0] cs_vec;
    wire [7:0] ilas_vec;
    wire [7:0] data_vec;
    wire       link0_en;
    wire       link1_en;
    wire       link_sel;
    wire       cgs_ok;
    wire       sync_next;
    wire [3:0] sel_data;
    wire [31:0] fifo_word;
    wire       fifo_push;
    reg  [7:0] rdata_next;

    // ======================================================================
    // Selected-link field helper
    function [7:0] link_field;
        input [7:0] vec;
        input       sel;
        begin
            link_field = {4'h0, (sel ? vec[7:4] : vec[3:0])};
        end
    endfunction

    assign link0_en = link_ctrl_reg[`BIT_LINK0_ENABLE];
    assign link1_en = link_ctrl_reg[`BIT_LINK1_ENABLE];
    assign link_sel = link_ctrl_reg[`BIT_LINK_SELECT];
    assign pll_enable = pll_en_reg[`BIT_PLL_ENABLE];

    // ======================================================================
    // Register writes and sync machine
    assign sysref_edge = sysref && !sysref_prev_reg;
    assign align_now   = sysref_edge && sync_ctrl_reg[`BIT_SYNC_ENABLE] &&
                         (sync_ctrl_reg[`BIT_SYNC_ARM] ||
                          !sync_ctrl_reg[`BIT_SYNC_ONE_SHOT]);

    always @(posedge core_clk) begin
        if (!reset_n) begin
            sync_ctrl_reg   <= `RST_BYTE;
            eq_mode_reg     <= `RST_BYTE;
            pll_en_reg      <= `RST_BYTE;
            link_ctrl_reg   <= `RST_BYTE;
            subclass_reg    <= `RST_SUBCLASS;
            mf_delay_a_reg  <= `RST_BYTE;
            mf_delay_b_reg  <= `RST_BYTE;
            rx_delay_a_reg  <= `RST_BYTE;
            rx_delay_b_reg  <= `RST_BYTE;
            sysref_prev_reg <= 1'b0;
        end else begin
            sysref_prev_reg <= sysref;
            if (reg_write) begin
                case (reg_addr)
                    `OFS_SYNC_MACHINE_CONTROL: begin
                        sync_ctrl_reg <= reg_wdata;
                    end
                    `OFS_RECEIVER_EQUALISER_MODE: begin
                        eq_mode_reg <= reg_wdata;
                    end
                    `OFS_LANE_PLL_ENABLE: begin
                        pll_en_reg <= reg_wdata;
                    end
                    `OFS_LINK_ENABLE_AND_SELECT: begin
                        link_ctrl_reg <= reg_wdata;
                    end
                    `OFS_LINK_SUBCLASS: begin
                        subclass_reg <= reg_wdata;
                    end
                    `OFS_MULTIFRAME_DELAY_A: begin
                        mf_delay_a_reg <= reg_wdata;
                    end
                    `OFS_MULTIFRAME_DELAY_B: begin
                        mf_delay_b_reg <= reg_wdata;
                    end
                    `OFS_RECEIVE_BUFFER_DELAY_A: begin
                        rx_delay_a_reg <= reg_wdata;
                    end
                    `OFS_RECEIVE_BUFFER_DELAY_B: begin
                        rx_delay_b_reg <= reg_wdata;
                    end
                    default: begin
                    end
                endcase
            end
            // Hardware disarm wins over a same-cycle write
            if (align_now && sync_ctrl_reg[`BIT_SYNC_ONE_SHOT]) begin
                sync_ctrl_reg[`BIT_SYNC_ARM] <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Local multiframe clock, realigned by the sync machine
    always @* begin
        lmfc_cnt_next = lmfc_cnt_reg + 8'h01;
        if (align_now || lmfc_cnt_next >= `LMFC_PERIOD) begin
            lmfc_cnt_next = 8'h00;
        end
    end

    always @(posedge core_clk) begin
        if (!reset_n) begin
            lmfc_cnt_reg <= 8'h00;
        end else begin
            lmfc_cnt_reg <= lmfc_cnt_next;
        end
    end

    assign lmfc_boundary = (lmfc_cnt_reg == 8'h00);

    // ======================================================================
    // Per-lane receive state
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : lane
            wire [7:0] ch;
            wire       k;
            wire       en;
            reg  [2:0] state_reg;
            reg  [2:0] kcnt_reg;
            reg  [3:0] cfg_cnt_reg;
            reg  [7:0] sum_reg;
            reg        fs_reg;
            reg        cs_reg;
            reg        ilas_reg;
            reg        last_a_reg;

            assign ch = serial_lane_inputs[g*8 +: 8];
            assign k  = lane_is_control[g];
            assign en = (g < 4) ? link0_en : link1_en;

            always @(posedge core_clk) begin
                if (!reset_n || !en) begin
                    state_reg   <= ST_CGS;
                    kcnt_reg    <= 3'h0;
                    cfg_cnt_reg <= 4'h0;
                    sum_reg     <= 8'h00;
                    fs_reg      <= 1'b0;
                    cs_reg      <= 1'b0;
                    ilas_reg    <= 1'b0;
                    last_a_reg  <= 1'b0;
                end else if (lane_valid[g]) begin
                    case (state_reg)
                        ST_CGS: begin
                            if (k && ch == `CHAR_K28_5) begin
                                if (kcnt_reg == `CGS_COUNT - 3'h1) begin
                                    state_reg <= ST_WAIT;
                                end
                                kcnt_reg <= kcnt_reg + 3'h1;
                            end else begin
                                kcnt_reg <= 3'h0;
                            end
                        end
                        ST_WAIT: begin
                            if (k && ch == `CHAR_K28_0) begin
                                fs_reg    <= 1'b1;
                                state_reg <= ST_ILAS;
                            end else if (!(k && ch == `CHAR_K28_5)) begin
                                state_reg <= ST_CGS;
                                kcnt_reg  <= 3'h0;
                            end
                        end
                        ST_ILAS: begin
                            last_a_reg <= k && ch == `CHAR_K28_3;
                            if (k && ch == `CHAR_K28_4) begin
                                state_reg   <= ST_CFG;
                                cfg_cnt_reg <= 4'h0;
                                sum_reg     <= 8'h00;
                            end else if (!k && last_a_reg && cs_reg) begin
                                ilas_reg  <= 1'b1;
                                state_reg <= ST_DATA;
                            end
                        end
                        ST_CFG: begin
                            cfg_cnt_reg <= cfg_cnt_reg + 4'h1;
                            if (cfg_cnt_reg == `ILAS_CONFIG_LEN - 4'h1) begin
                                cs_reg    <= (sum_reg == ch);
                                state_reg <= ST_ILAS;
                            end else begin
                                sum_reg <= sum_reg + ch;
                            end
                        end
                        ST_DATA: begin
                            if (k && ch == `CHAR_K28_5) begin
                                state_reg <= ST_CGS;
                                kcnt_reg  <= 3'h0;
                                fs_reg    <= 1'b0;
                            end
                        end
                        default: begin
                            state_reg <= ST_CGS;
                        end
                    endcase
                end
            end

            assign cgs_vec[g]  = (state_reg != ST_CGS);
            assign fs_vec[g]   = fs_reg;
            assign cs_vec[g]   = cs_reg;
            assign ilas_vec[g] = ilas_reg;
            assign data_vec[g] = (state_reg == ST_DATA) && lane_valid[g];
        end
    endgenerate

    // ======================================================================
    // Sync request, released on a multiframe boundary in subclass 1
    assign cgs_ok = (link0_en || link1_en) &&
                    (!link0_en || (&cgs_vec[3:0])) &&
                    (!link1_en || (&cgs_vec[7:4]));
    assign sync_next = cgs_ok && (sync_request_output || lmfc_boundary ||
                       subclass_reg != `SUBCLASS_ONE);

    always @(posedge core_clk) begin
        if (!reset_n) begin
            sync_request_output <= 1'b0;
        end else begin
            sync_request_output <= sync_next;
        end
    end

    // ======================================================================
    // Sample path of the selected link; no buffer-delay release is applied
    assign sel_data  = link_sel ? data_vec[7:4] : data_vec[3:0];
    assign fifo_word = link_sel ? serial_lane_inputs[63:32]
                                : serial_lane_inputs[31:0];
    assign fifo_push = &sel_data;

    data_fifo #(
        .WIDTH (32),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .in_data   (fifo_word),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .out_data  (sample_data),
        .out_valid (sample_valid),
        .out_ready (sample_ready)
    );

    // ======================================================================
    // Register read-back
    always @* begin
        rdata_next = 8'h00;
        case (reg_addr)
            `OFS_SYNC_MACHINE_CONTROL:      rdata_next = sync_ctrl_reg;
            `OFS_RECEIVER_EQUALISER_MODE:   rdata_next = eq_mode_reg;
            `OFS_LANE_PLL_ENABLE:           rdata_next = pll_en_reg;
            `OFS_LANE_PLL_LOCK_STATUS: begin
                rdata_next[`BIT_PLL_LOCKED] = pll_enable && pll_locked;
            end
            `OFS_LINK_ENABLE_AND_SELECT:    rdata_next = link_ctrl_reg;
            `OFS_LINK_SUBCLASS:             rdata_next = subclass_reg;
            `OFS_MULTIFRAME_DELAY_A:        rdata_next = mf_delay_a_reg;
            `OFS_MULTIFRAME_DELAY_B:        rdata_next = mf_delay_b_reg;
            `OFS_RECEIVE_BUFFER_DELAY_A:    rdata_next = rx_delay_a_reg;
            `OFS_RECEIVE_BUFFER_DELAY_B:    rdata_next = rx_delay_b_reg;
            `OFS_CODE_GROUP_SYNC_STATUS: begin
                rdata_next = link_field(cgs_vec, link_sel);
            end
            `OFS_FRAME_SYNC_STATUS: begin
                rdata_next = link_field(fs_vec, link_sel);
            end
            `OFS_CHECKSUM_GOOD_STATUS: begin
                rdata_next = link_field(cs_vec, link_sel);
            end
            `OFS_ALIGNMENT_SEQUENCE_STATUS: begin
                rdata_next = link_field(ilas_vec, link_sel);
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= rdata_next;
        end
    end

endmodule

// ### tb/link_bringup_asserts.sv
// Checker for the link bring-up block, bound to its top module.
// Assumes subclass 1 is programmed before any link is enabled.
module link_bringup_checker (
    input logic        core_clk,
    input logic        reset_n,
    input logic [11:0] reg_addr,
    input logic [7:0]  reg_wdata,
    input logic        reg_write,
    input logic        reg_read,
    input logic [7:0]  reg_rdata,
    input logic        pll_enable,
    input logic        pll_locked,
    input logic        sysref,
    input logic        sync_request_output,
    input logic        lmfc_boundary,
    input logic        fifo_in_ready,
    input logic [31:0] sample_data,
    input logic        sample_valid,
    input logic        sample_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] gap_reg;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    // ============================================================
    // Cycles since the last multiframe boundary
    always_ff @(posedge core_clk) begin
        if (!reset_n)
            gap_reg <= 6'h20;
        else if (lmfc_boundary)
            gap_reg <= 6'h01;
        else if (gap_reg != 6'h3F)
            gap_reg <= gap_reg + 6'h01;
    end

    // ============================================================
    // Assertions and covers
    pll_follow_a: assert property (reg_write && reg_addr == 12'h280
        |=> pll_enable == $past(reg_wdata[0]))
        else $error("pll enable does not follow its register");
    pll_lock_read_a: assert property (reg_read && reg_addr == 12'h281
        |=> reg_rdata == {7'h00, $past(pll_enable && pll_locked)})
        else $error("lock status read is wrong");
    status_upper_a: assert property (reg_read && reg_addr[11:2] == 10'h11C
        |=> reg_rdata[7:4] == 4'h0)
        else $error("status upper bits not zero");
    rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    sync_rise_a: assert property ($rose(sync_request_output)
        |-> $past(lmfc_boundary))
        else $error("sync request rose off a boundary");
    lmfc_period_a: assert property (lmfc_boundary
        && !$past(sysref) && !$past(sysref, 2) |-> gap_reg == 6'h20)
        else $error("boundary moved without a reference edge");
    fifo_hold_a: assert property (sample_valid && !sample_ready
        |=> sample_valid && $stable(sample_data))
        else $error("fifo head changed while stalled");
    full_nonempty_a: assert property (!fifo_in_ready |-> sample_valid)
        else $error("fifo full yet empty");
    reset_state_a: assert property ($rose(reset_n) |-> !sync_request_output
        && !sample_valid && fifo_in_ready && lmfc_boundary && !pll_enable)
        else $error("outputs wrong after reset");
    sync_c: cover property ($rose(sync_request_output));
    full_c: cover property (!fifo_in_ready);
    sysref_c: cover property ($rose(sysref));
endmodule

bind link_bringup link_bringup_checker i_checker (
    .core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .pll_enable, .pll_locked, .sysref, .sync_request_output,
    .lmfc_boundary, .fifo_in_ready, .sample_data, .sample_valid,
    .sample_ready
);

// ### tb/lane_tx_model.sv
// Transmitter model driving eight decoded lanes with the same stream.
// Assumes a high sync request means the receiver wants ILAS then data.
module lane_tx_model (
    input  logic        core_clk,
    input  logic        sync_request_output,
    input  logic        pace,
    output logic [63:0] serial_lane_inputs = 64'h0,
    output logic [7:0]  lane_is_control = 8'h00,
    output logic [7:0]  lane_valid = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] idx_reg = 16'h0000;
    logic        tick = 1'b0;
    logic [7:0]  oct;
    logic        k;

    // ============================================================
    // Octet for the current position of the sequence
    always_comb begin
        k = 1'b1;
        oct = 8'hBC;
        if (!sync_request_output)
            oct = 8'hBC;
        else if (idx_reg == 16'h0)
            oct = 8'h1C;
        else if (idx_reg == 16'h1)
            oct = 8'h9C;
        else if (idx_reg < 16'hF)
            {k, oct} = {1'b0, idx_reg[7:0] - 8'h01};
        else if (idx_reg == 16'hF)
            {k, oct} = {1'b0, 8'h5B};
        else if (idx_reg == 16'h10)
            oct = 8'h7C;
        else
            {k, oct} = {1'b0, idx_reg[7:0]};
    end

    // ============================================================
    // Launch; slow pace sends every other cycle, idle lines toggle
    always @(negedge core_clk) begin
        tick <= ~tick;
        lane_valid <= {8{!pace || tick}};
        if (!pace || tick) begin
            lane_is_control <= {8{k}};
            serial_lane_inputs <= {8{oct}};
            idx_reg <= sync_request_output ? idx_reg + 16'h1 : 16'h0;
        end else begin
            lane_is_control <= ~lane_is_control;
            serial_lane_inputs <= ~serial_lane_inputs;
            if (!sync_request_output)
                idx_reg <= 16'h0;
        end
    end
endmodule

// ### tb/tb.sv
// Self-checking bench for the link bring-up block.
// Assumes the checker binds itself and the model feeds all lanes.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        pll_locked = 1'b0;
    logic        sysref = 1'b0;
    logic        sample_ready = 1'b0;
    logic        pace = 1'b0;
    wire  [7:0]  reg_rdata, lane_is_control, lane_valid;
    wire  [63:0] serial_lane_inputs;
    wire  [31:0] sample_data;
    wire         pll_enable, sync_request_output, lmfc_boundary;
    wire         fifo_in_ready, sample_valid;
    int          fails = 0;
    int          checks_done = 0;

    link_bringup i_dut (.core_clk, .reset_n, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .pll_enable, .pll_locked,
        .sysref, .serial_lane_inputs, .lane_is_control, .lane_valid,
        .sync_request_output, .lmfc_boundary, .fifo_in_ready,
        .sample_data, .sample_valid, .sample_ready);
    lane_tx_model i_tx (.core_clk, .sync_request_output, .pace,
        .serial_lane_inputs, .lane_is_control, .lane_valid);

    initial forever #50 core_clk = ~core_clk;

    // ============================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge core_clk);
        {reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
        @(negedge core_clk);
        reg_write = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(negedge core_clk);
        {reg_addr, reg_read} = {a, 1'b1};
        @(negedge core_clk);
        reg_read = 1'b0;
        @(negedge core_clk);
        check(reg_rdata, e, $sformatf("reg %h", a));
    endtask
    task automatic to_boundary(output int n);
        for (n = 0; n < 40 && lmfc_boundary !== 1'b1; n++)
            @(negedge core_clk);
    endtask
    task automatic wait_sync(input logic lvl);
        for (int n = 0; n < 400 && sync_request_output !== lvl; n++)
            @(negedge core_clk);
    endtask
    task automatic status_all;
        for (int i = 0; i < 4; i++)
            rd(12'h470 + 12'(i), 8'h0F);
    endtask

    // ============================================================
    // Scenarios
    task automatic bringup_regs;
        logic [11:0] ofs [6] = '{12'h268, 12'h301, 12'h304, 12'h305,
                                 12'h306, 12'h307};
        logic [7:0]  val [6] = '{8'h62, 8'h01, 8'h00, 8'h00, 8'h0A, 8'h0A};
        wr(12'h280, 8'h01);
        rd(12'h281, 8'h00);
        pll_locked = 1'b1;
        rd(12'h281, 8'h01);
        foreach (ofs[i]) begin
            rd(ofs[i], 8'h00);
            wr(ofs[i], val[i]);
            rd(ofs[i], val[i]);
        end
        wr(12'h470, 8'h5A);
        rd(12'h470, 8'h00);
        rd(12'hC23, 8'h00);
    endtask
    task automatic one_shot_sync;
        int n;
        wr(12'h03A, 8'h01);
        wr(12'h03A, 8'h81);
        wr(12'h03A, 8'hC1);
        rd(12'h03A, 8'hC1);
        to_boundary(n);
        repeat (10) @(negedge core_clk);
        sysref = 1'b1;
        @(negedge core_clk);
        sysref = 1'b0;
        to_boundary(n);
        check(n < 2, 1, "realign delay");
        rd(12'h03A, 8'h81);
        to_boundary(n);
        @(negedge core_clk);
        to_boundary(n);
        check(n, 31, "lmfc period");
        repeat (10) @(negedge core_clk);
        sysref = 1'b1;
        @(negedge core_clk);
        sysref = 1'b0;
        to_boundary(n);
        check(n, 21, "no second realign");
        wr(12'h03A, 8'h80);
        repeat (10) @(negedge core_clk);
        sysref = 1'b1;
        @(negedge core_clk);
        sysref = 1'b0;
        to_boundary(n);
        check(n < 2, 1, "continuous realign");
    endtask
    task automatic link0_first;
        rd(12'h470, 8'h00);
        wr(12'h300, 8'h01);
        wait_sync(1'b1);
        check(sync_request_output, 1, "sync request");
        repeat (60) @(negedge core_clk);
        status_all;
        wr(12'h300, 8'h05);
        rd(12'h470, 8'h00);
    endtask
    task automatic both_links;
        pace = 1'b1;
        wr(12'h300, 8'h0B);
        wait_sync(1'b0);
        wait_sync(1'b1);
        check(sync_request_output, 1, "sync both links");
        repeat (80) @(negedge core_clk);
        status_all;
        wr(12'h300, 8'h0F);
        status_all;
    endtask
    task automatic fifo_drain;
        logic [7:0] first;
        check(fifo_in_ready, 0, "fifo_in_ready");
        wr(12'h300, 8'h00);
        first = sample_data[7:0];
        check(first, 8'h12, "first sample");
        for (int i = 0; i < 32; i++) begin
            check(sample_data, {4{first + i[7:0]}}, "sample_data");
            sample_ready = 1'b1;
            @(negedge core_clk);
            sample_ready = 1'b0;
            @(negedge core_clk);
        end
        check(sample_valid, 0, "sample_valid");
    endtask

    // ============================================================
    // Sequence, watchdog and verdict
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge core_clk);
        reset_n = 1'b1;
        bringup_regs;
        one_shot_sync;
        link0_first;
        both_links;
        fifo_drain;
        report_and_stop;
    end
    initial begin
        #1ms;
        fails++;
        report_and_stop;
    end
endmodule
